/* File: hdl/bsp_ctrl.sv */
// Two-channel buck gate sequencer with APB configuration.
// Summary of operation
// R1: Inaudible skip forces on after skip limit.
// R2: Overvoltage after forced pulse trims skip on-time.
// R3: Inaudible skip limit is 7 or 15.
// R4: Full-duty demand gets forced off for bootstrap.
// R5: Dead time between every gate transition.
// R6: Sense gain follows trip select setting.
// R7: Overcurrent ends high pulse, low on, wait.
// R8: Trip select sets threshold and discharge enable.
// R9: Sustained overcurrent ends in undervoltage shutdown.
// R10: Adaptive zero-cross offset in skip mode.
// R11: Separate powergood output per channel.
// R12: Powergood idle until soft-start completes.
// R13: Powergood rises after 1 ms in window.
// R14: Powergood falls after 1.5 us outside.
// R15: Discharge switch on while disabled, enabled.
// R16: Enable opens discharge; switch after target overtakes.
// R17: Skip select decodes four light-load modes.
// R18: Undervoltage 1 ms latches off both channels.
// R19: Skip counter clears on high-side, counts cycles.
// R20: Overcurrent cut lasts only current cycle.
module bsp_ctrl #(
	parameter int unsigned PG_RISE_CYCLES = bsp_pkg::PG_RISE_CYC,
	parameter int unsigned UV_CYCLES = bsp_pkg::UV_DELAY_CYC
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [1:0] channel_enable_i,
	input wire logic [1:0] loop_demand_i,
	input wire logic [1:0] loop_off_i,
	input wire logic [1:0] overcurrent_limit_i,
	input wire logic [1:0] zero_cross_detect_i,
	input wire logic [1:0] overvoltage_i,
	input wire logic [1:0] switch_node_swing_i,
	input wire logic [1:0] switch_node_diode_i,
	input wire logic [1:0] target_above_residual_i,
	input wire logic [1:0] soft_start_done_i,
	input wire logic [1:0] pg_in_window_i,
	input wire logic [1:0] pg_out_window_i,
	input wire logic [1:0] under_voltage_i,
	output logic [1:0] high_gate_drive_o,
	output logic [1:0] low_gate_drive_o,
	output logic [1:0] discharge_o,
	output logic [1:0] powergood_o,
	output logic sense_amp_gain_o,
	output logic [7:0] zc_offset_o
);

	if (PG_RISE_CYCLES < 1 || PG_RISE_CYCLES > 65535 ||
		UV_CYCLES < 1 || UV_CYCLES > 65535) begin : g_chk
		$error("Delay counts must lie between 1 and 65535.");
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [25:0] pin_raw, s1_reg, s2_reg, s3_reg, pin_reg, pin_next;
	logic [1:0] en, dem, off, oc, zc, ov, swu, dio, res;

	assign pin_raw = {under_voltage_i, pg_out_window_i, pg_in_window_i,
		soft_start_done_i, target_above_residual_i, switch_node_diode_i,
		switch_node_swing_i, overvoltage_i, zero_cross_detect_i,
		overcurrent_limit_i, loop_off_i, loop_demand_i, channel_enable_i};

	always_comb begin
		for (int i = 0; i < 26; i++) begin
			pin_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : pin_reg[i];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			pin_reg <= '0;
		end else begin
			s1_reg <= pin_raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			pin_reg <= pin_next;
		end
	end

	assign en = pin_reg[1:0];
	assign dem = pin_reg[3:2];
	assign off = pin_reg[5:4];
	assign oc = pin_reg[7:6];
	assign zc = pin_reg[9:8];
	assign ov = pin_reg[11:10];
	assign swu = pin_reg[13:12];
	assign dio = pin_reg[15:14];
	assign res = pin_reg[17:16];

	// ----------------------------------------------------------------
	// Supervisor
	// ----------------------------------------------------------------
	bsp_sup_if sif ();

	assign sif.enable = en;
	assign sif.ss_done = pin_reg[19:18];
	assign sif.in_window = pin_reg[21:20];
	assign sif.out_window = pin_reg[23:22];
	assign sif.under_volt = pin_reg[25:24];
	assign powergood_o = sif.powergood;

	bsp_supervisor #(
		.PG_RISE_CYCLES(PG_RISE_CYCLES),
		.UV_CYCLES(UV_CYCLES)
	) u_sup (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.sif(sif)
	);

	// ----------------------------------------------------------------
	// APB registers
	// ----------------------------------------------------------------
	logic [5:0] ctrl_reg, ctrl_next;
	logic [15:0] period_reg, period_next;
	logic [11:0] dead_reg, dead_next;
	logic [31:0] prdata_reg, prdata_next;
	logic [1:0][3:0] skip_reg, skip_next;
	logic [1:0][3:0] ofs_reg, ofs_next;
	logic apb_hit, apb_wr;

	function automatic logic mapped(input logic [11:0] a);
		return a == bsp_pkg::ADDR_CTRL || a == bsp_pkg::ADDR_PERIOD ||
			a == bsp_pkg::ADDR_DEAD || a == bsp_pkg::ADDR_STAT;
	endfunction

	assign apb_hit = mapped(paddr_i);
	assign apb_wr = psel_i && penable_i && pwrite_i && apb_hit;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !apb_hit;
	assign prdata_o = prdata_reg;

	always_comb begin
		ctrl_next = ctrl_reg;
		period_next = period_reg;
		dead_next = dead_reg;
		prdata_next = prdata_reg;
		if (apb_wr && paddr_i == bsp_pkg::ADDR_CTRL) begin
			ctrl_next = pwdata_i[5:0];
		end
		if (apb_wr && paddr_i == bsp_pkg::ADDR_PERIOD) begin
			period_next = pwdata_i[15:0];
		end
		if (apb_wr && paddr_i == bsp_pkg::ADDR_DEAD) begin
			dead_next = pwdata_i[11:0];
		end
		// Read data is fetched in the setup cycle for a zero-wait answer.
		if (psel_i && !penable_i) begin
			prdata_next = 32'h0000_0000;
			case (paddr_i)
				bsp_pkg::ADDR_CTRL: prdata_next[5:0] = ctrl_reg;
				bsp_pkg::ADDR_PERIOD: prdata_next[15:0] = period_reg;
				bsp_pkg::ADDR_DEAD: prdata_next[11:0] = dead_reg;
				bsp_pkg::ADDR_STAT: begin
					prdata_next[bsp_pkg::STAT_SKIP_LSB +: 8] = skip_reg;
					prdata_next[bsp_pkg::STAT_ZC_LSB +: 8] = ofs_reg;
					prdata_next[bsp_pkg::STAT_PG_LSB +: 2] = sif.powergood;
					prdata_next[bsp_pkg::STAT_UV_LSB +: 2] = sif.uv_fault;
				end
				default: prdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ctrl_reg <= bsp_pkg::CTRL_RST;
			period_reg <= bsp_pkg::PERIOD_RST;
			dead_reg <= bsp_pkg::DEAD_RST;
			prdata_reg <= 32'h0000_0000;
		end else begin
			ctrl_reg <= ctrl_next;
			period_reg <= period_next;
			dead_reg <= dead_next;
			prdata_reg <= prdata_next;
		end
	end

	// ----------------------------------------------------------------
	// Switching clock, channel 2 offset by half a period
	// ----------------------------------------------------------------
	logic [15:0] div_reg, div_next, per;
	logic [1:0] cyc;

	assign per = (period_reg < bsp_pkg::PERIOD_MIN) ? bsp_pkg::PERIOD_MIN :
		period_reg;
	assign div_next = (div_reg >= per - 16'h0001) ? 16'h0000 :
		div_reg + 16'h0001;
	assign cyc[0] = div_reg == 16'h0000;
	assign cyc[1] = div_reg == {1'b0, per[15:1]};

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			div_reg <= 16'h0000;
		end else begin
			div_reg <= div_next;
		end
	end

	// ----------------------------------------------------------------
	// Channel sequencers
	// ----------------------------------------------------------------
	bsp_pkg::bsp_ch_state_e st_reg [2];
	bsp_pkg::bsp_ch_state_e st_next [2];
	logic [1:0][7:0] tmr_reg, tmr_next;
	logic [1:0][15:0] on_reg, on_next, ton_reg, ton_next;
	logic [1:0] frc_reg, frc_next, fpend_reg, fpend_next;
	logic [1:0] ovf_reg, ovf_next, full_reg, full_next;
	logic [1:0] zcp_reg, zcp_next;
	logic [1:0] hs_reg, hs_next, ls_reg, ls_next, dis_reg, dis_next;
	logic gain_reg, gain_next;
	logic [1:0] mode;
	logic [1:0] trip;
	logic [3:0] lim;
	logic [7:0] dt, minoff;
	logic start, force_on, fire, ccm, dis_en;

	assign trip = ctrl_reg[bsp_pkg::CTRL_TRIP_LSB +: 2];
	assign dt = {4'h0, dead_reg[bsp_pkg::DEAD_LSB +: 4]};
	assign minoff = dead_reg[bsp_pkg::MINOFF_LSB +: 8];
	assign dis_en = trip == bsp_pkg::TRIP_GND || trip == bsp_pkg::TRIP_5V; // R8
	assign gain_next = trip == bsp_pkg::TRIP_GND ||
		trip == bsp_pkg::TRIP_REF2; // R6 R8

	always_comb begin
		mode = 2'h0;
		lim = 4'h0;
		start = 1'b0;
		force_on = 1'b0;
		fire = 1'b0;
		ccm = 1'b0;
		for (int c = 0; c < 2; c++) begin
			st_next[c] = st_reg[c];
			tmr_next[c] = tmr_reg[c];
			on_next[c] = on_reg[c];
			ton_next[c] = ton_reg[c];
			skip_next[c] = skip_reg[c];
			ofs_next[c] = ofs_reg[c];
			frc_next[c] = frc_reg[c];
			fpend_next[c] = fpend_reg[c];
			full_next[c] = full_reg[c];
			zcp_next[c] = zcp_reg[c];
			ovf_next[c] = ovf_reg[c] | (fpend_reg[c] & ov[c]);
			mode = ctrl_reg[bsp_pkg::CTRL_SKIP_LSB + 2 * c +: 2]; // R17
			ccm = mode == bsp_pkg::SKIP_CCM;
			lim = (mode == bsp_pkg::SKIP_OOA15) ? bsp_pkg::LIMIT_15 :
				bsp_pkg::LIMIT_7; // R3
			case (st_reg[c])
				bsp_pkg::CH_OFF: begin
					if (en[c]) begin
						st_next[c] = bsp_pkg::CH_SOFT; // R16
					end
				end
				bsp_pkg::CH_SOFT: begin
					if (res[c]) begin
						st_next[c] = bsp_pkg::CH_IDLE; // R16
					end
				end
				bsp_pkg::CH_IDLE: begin
					if (zcp_reg[c]) begin
						tmr_next[c] = tmr_reg[c] + 8'h01;
						if (tmr_reg[c] >= dt) begin
							zcp_next[c] = 1'b0;
							if (swu[c] && ofs_reg[c] != 4'hF) begin
								ofs_next[c] = ofs_reg[c] + 4'h1; // R10
							end else if (dio[c] && ofs_reg[c] != 4'h0) begin
								ofs_next[c] = ofs_reg[c] - 4'h1; // R10
							end
						end
					end
				end
				bsp_pkg::CH_DEAD_H: begin
					tmr_next[c] = tmr_reg[c] + 8'h01;
					if (tmr_reg[c] >= dt) begin
						st_next[c] = oc[c] ? bsp_pkg::CH_DEAD_L :
							bsp_pkg::CH_HIGH; // R5 R20
						on_next[c] = 16'h0000;
						tmr_next[c] = 8'h00;
					end
				end
				bsp_pkg::CH_HIGH: begin
					on_next[c] = on_reg[c] + 16'h0001;
					tmr_next[c] = 8'h00;
					if (oc[c]) begin
						st_next[c] = bsp_pkg::CH_DEAD_L; // R7 R20
					end else if (cyc[c]) begin
						full_next[c] = 1'b1; // R4
						st_next[c] = bsp_pkg::CH_DEAD_L;
					end else if (frc_reg[c] ? on_reg[c] >= ton_reg[c] :
						off[c]) begin
						st_next[c] = bsp_pkg::CH_DEAD_L; // R2
					end
				end
				bsp_pkg::CH_DEAD_L: begin
					tmr_next[c] = tmr_reg[c] + 8'h01;
					if (tmr_reg[c] >= dt) begin
						st_next[c] = bsp_pkg::CH_LOW; // R5
						tmr_next[c] = 8'h00;
					end
				end
				bsp_pkg::CH_LOW: begin
					if (tmr_reg[c] != 8'hFF) begin
						tmr_next[c] = tmr_reg[c] + 8'h01;
					end
					if (full_reg[c] && tmr_reg[c] >= minoff) begin
						full_next[c] = 1'b0; // R4
						skip_next[c] = 4'h0;
						frc_next[c] = 1'b0;
						st_next[c] = bsp_pkg::CH_DEAD_H;
						tmr_next[c] = 8'h00;
					end else if (!ccm && zc[c]) begin
						st_next[c] = bsp_pkg::CH_IDLE; // R10
						zcp_next[c] = 1'b1;
						tmr_next[c] = 8'h00;
					end
				end
				bsp_pkg::CH_FAULT: begin
					tmr_next[c] = 8'h00;
				end
				default: st_next[c] = bsp_pkg::CH_OFF;
			endcase
			// Cycle start: pulse, forced pulse or counted skip.
			start = cyc[c] && (st_reg[c] == bsp_pkg::CH_IDLE ||
				(st_reg[c] == bsp_pkg::CH_LOW && !full_reg[c]));
			force_on = !ccm && !dem[c] && mode[1] && skip_reg[c] >= lim;
			fire = start && (ccm || dem[c] || force_on);
			if (start && fpend_reg[c]) begin
				fpend_next[c] = 1'b0;
				ovf_next[c] = 1'b0;
				if (ovf_next[c] || ovf_reg[c]) begin
					if (ton_reg[c] > bsp_pkg::SKIP_TON_MIN) begin
						ton_next[c] = ton_reg[c] - 16'h0001; // R2
					end
				end else if (ton_reg[c] != 16'hFFFF) begin
					ton_next[c] = ton_reg[c] + 16'h0001; // R2
				end
			end
			if (fire) begin
				skip_next[c] = 4'h0; // R19
				frc_next[c] = force_on; // R1
				fpend_next[c] = force_on;
				zcp_next[c] = 1'b0;
				st_next[c] = bsp_pkg::CH_DEAD_H;
				tmr_next[c] = 8'h00;
			end else if (start && skip_reg[c] != 4'hF) begin
				skip_next[c] = skip_reg[c] + 4'h1; // R19 R1
			end
			if (!en[c]) begin
				st_next[c] = bsp_pkg::CH_OFF;
				full_next[c] = 1'b0;
				zcp_next[c] = 1'b0;
				fpend_next[c] = 1'b0;
			end else if (|sif.uv_fault) begin
				st_next[c] = bsp_pkg::CH_FAULT; // R18 R9
			end
			hs_next[c] = st_next[c] == bsp_pkg::CH_HIGH;
			ls_next[c] = st_next[c] == bsp_pkg::CH_LOW; // R7
			dis_next[c] = st_next[c] == bsp_pkg::CH_OFF && !en[c] &&
				dis_en; // R15 R16
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			for (int c = 0; c < 2; c++) begin
				st_reg[c] <= bsp_pkg::CH_OFF;
			end
			tmr_reg <= '0;
			on_reg <= '0;
			ton_reg <= {2{bsp_pkg::SKIP_TON_RST}};
			skip_reg <= '0;
			ofs_reg <= {2{bsp_pkg::ZC_OFS_RST}};
			frc_reg <= 2'h0;
			fpend_reg <= 2'h0;
			ovf_reg <= 2'h0;
			full_reg <= 2'h0;
			zcp_reg <= 2'h0;
			hs_reg <= 2'h0;
			ls_reg <= 2'h0;
			dis_reg <= 2'h0;
			gain_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			tmr_reg <= tmr_next;
			on_reg <= on_next;
			ton_reg <= ton_next;
			skip_reg <= skip_next;
			ofs_reg <= ofs_next;
			frc_reg <= frc_next;
			fpend_reg <= fpend_next;
			ovf_reg <= ovf_next;
			full_reg <= full_next;
			zcp_reg <= zcp_next;
			hs_reg <= hs_next;
			ls_reg <= ls_next;
			dis_reg <= dis_next;
			gain_reg <= gain_next;
		end
	end

	assign high_gate_drive_o = hs_reg;
	assign low_gate_drive_o = ls_reg;
	assign discharge_o = dis_reg;
	assign sense_amp_gain_o = gain_reg;
	assign zc_offset_o = ofs_reg;

endmodule : bsp_ctrl

/* File: hdl/bsp_pkg.sv */
// Constants, register map and types of the buck channel sequencer.
package bsp_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int unsigned PG_RISE_US = 1000;
	localparam int unsigned PG_RISE_CYC = PG_RISE_US * CYC_PER_US;
	localparam int unsigned PG_FALL_NS = 1500;
	localparam int unsigned PG_FALL_CALC = PG_FALL_NS * CYC_PER_US / 1000;
	localparam int unsigned PG_FALL_CYC = (PG_FALL_CALC < 1) ? 1 :
		PG_FALL_CALC;
	localparam int unsigned UV_DELAY_US = 1000;
	localparam int unsigned UV_DELAY_CYC = UV_DELAY_US * CYC_PER_US;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_PERIOD = 12'h004;
	localparam logic [11:0] ADDR_DEAD = 12'h008;
	localparam logic [11:0] ADDR_STAT = 12'h00C;
	localparam int unsigned CTRL_SKIP_LSB = 0;
	localparam int unsigned CTRL_TRIP_LSB = 4;
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [15:0] PERIOD_RST = 16'h0064;
	localparam logic [15:0] PERIOD_MIN = 16'h0002;
	localparam int unsigned DEAD_LSB = 0;
	localparam int unsigned MINOFF_LSB = 4;
	localparam logic [11:0] DEAD_RST = 12'h0A2;
	localparam int unsigned STAT_SKIP_LSB = 0;
	localparam int unsigned STAT_ZC_LSB = 8;
	localparam int unsigned STAT_PG_LSB = 16;
	localparam int unsigned STAT_UV_LSB = 18;

	// ----------------------------------------------------------------
	// Mode codes and limits
	// ----------------------------------------------------------------
	localparam logic [1:0] SKIP_CCM = 2'h0;
	localparam logic [1:0] SKIP_AUTO = 2'h1;
	localparam logic [1:0] SKIP_OOA7 = 2'h2;
	localparam logic [1:0] SKIP_OOA15 = 2'h3;
	localparam logic [3:0] LIMIT_7 = 4'h7;
	localparam logic [3:0] LIMIT_15 = 4'hF;
	localparam logic [1:0] TRIP_GND = 2'h0;
	localparam logic [1:0] TRIP_REF2 = 2'h1;
	localparam logic [1:0] TRIP_3V3 = 2'h2;
	localparam logic [1:0] TRIP_5V = 2'h3;
	localparam logic [15:0] SKIP_TON_RST = 16'h0010;
	localparam logic [15:0] SKIP_TON_MIN = 16'h0001;
	localparam logic [3:0] ZC_OFS_RST = 4'h8;

	typedef enum {
		CH_OFF, CH_SOFT, CH_IDLE, CH_DEAD_H,
		CH_HIGH, CH_DEAD_L, CH_LOW, CH_FAULT
	} bsp_ch_state_e;

endpackage : bsp_pkg

/* File: hdl/bsp_sup_if.sv */
// Interface between the sequencer and the channel supervisor.
interface bsp_sup_if;
	logic [1:0] enable;
	logic [1:0] ss_done;
	logic [1:0] in_window;
	logic [1:0] out_window;
	logic [1:0] under_volt;
	logic [1:0] powergood;
	logic [1:0] uv_fault;
	modport seq (output enable, ss_done, in_window, out_window,
		under_volt, input powergood, uv_fault);
	modport sup (input enable, ss_done, in_window, out_window,
		under_volt, output powergood, uv_fault);
endinterface : bsp_sup_if

/* File: hdl/bsp_supervisor.sv */
// Powergood delay filters and undervoltage delay latch, both channels.
module bsp_supervisor #(
	parameter int unsigned PG_RISE_CYCLES = bsp_pkg::PG_RISE_CYC,
	parameter int unsigned UV_CYCLES = bsp_pkg::UV_DELAY_CYC
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	bsp_sup_if.sup sif
);

	localparam logic [15:0] RISE_END = 16'(PG_RISE_CYCLES - 1);
	localparam logic [15:0] FALL_END = 16'(bsp_pkg::PG_FALL_CYC - 1);
	localparam logic [15:0] UV_END = 16'(UV_CYCLES - 1);

	logic [1:0][15:0] pg_cnt_reg, pg_cnt_next;
	logic [1:0][15:0] uv_cnt_reg, uv_cnt_next;
	logic [1:0] pg_reg, pg_next;
	logic [1:0] uv_reg, uv_next;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			pg_cnt_next[c] = 16'h0000;
			pg_next[c] = pg_reg[c];
			uv_cnt_next[c] = 16'h0000;
			uv_next[c] = uv_reg[c];
			if (!sif.enable[c] || !sif.ss_done[c]) begin
				pg_next[c] = 1'b0; // R12
			end else if (pg_reg[c]) begin
				if (sif.out_window[c]) begin
					pg_cnt_next[c] = pg_cnt_reg[c] + 16'h0001;
					if (pg_cnt_reg[c] >= FALL_END) begin
						pg_next[c] = 1'b0; // R14
						pg_cnt_next[c] = 16'h0000;
					end
				end
			end else if (sif.in_window[c]) begin
				pg_cnt_next[c] = pg_cnt_reg[c] + 16'h0001;
				if (pg_cnt_reg[c] >= RISE_END) begin
					pg_next[c] = 1'b1; // R13
					pg_cnt_next[c] = 16'h0000;
				end
			end
			// Fault holds until the channel enable is toggled low.
			if (!sif.enable[c]) begin
				uv_next[c] = 1'b0;
			end else if (sif.ss_done[c] && sif.under_volt[c] &&
				!uv_reg[c]) begin
				uv_cnt_next[c] = uv_cnt_reg[c] + 16'h0001;
				if (uv_cnt_reg[c] >= UV_END) begin
					uv_next[c] = 1'b1; // R18 R9
				end
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			pg_cnt_reg <= '0;
			uv_cnt_reg <= '0;
			pg_reg <= 2'h0;
			uv_reg <= 2'h0;
		end else begin
			pg_cnt_reg <= pg_cnt_next;
			uv_cnt_reg <= uv_cnt_next;
			pg_reg <= pg_next;
			uv_reg <= uv_next;
		end
	end

	assign sif.powergood = pg_reg; // R11
	assign sif.uv_fault = uv_reg;

endmodule : bsp_supervisor

/* File: verification/bsp_ctrl_asserts.sv */
// Port checker of the buck channel sequencer, bound to its top module.
module bsp_ctrl_asserts #(
	parameter int unsigned PG_RISE_CYCLES = bsp_pkg::PG_RISE_CYC
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [1:0] channel_enable_i,
	input wire logic [1:0] overcurrent_limit_i,
	input wire logic [1:0] soft_start_done_i,
	input wire logic [1:0] pg_in_window_i,
	input wire logic [1:0] pg_out_window_i,
	input wire logic [1:0] high_gate_drive_o,
	input wire logic [1:0] low_gate_drive_o,
	input wire logic [1:0] discharge_o,
	input wire logic [1:0] powergood_o
);
	// Run lengths of the raw window inputs of channel 1; the in-window run also needs soft-start done and enable.
	logic [15:0] in_cnt_reg, in_cnt_next, out_cnt_reg, out_cnt_next;
	logic in_ok;
	assign in_ok = pg_in_window_i[0] & soft_start_done_i[0] & channel_enable_i[0];
	always_comb begin
		in_cnt_next = in_ok ? in_cnt_reg + 16'h0001 : 16'h0000;
		out_cnt_next = pg_out_window_i[0] ? out_cnt_reg + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge core_clk_i) begin
		in_cnt_reg <= reset_i ? 16'h0000 : in_cnt_next;
		out_cnt_reg <= reset_i ? 16'h0000 : out_cnt_next;
	end

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	sequence quiet_s(g);
		!g [*3];
	endsequence

	overlap_a: assert property (!(|(high_gate_drive_o & low_gate_drive_o)))
		else $error("Both gates on together.");
	gap_hl_a: assert property ($fell(high_gate_drive_o[0]) |-> quiet_s(low_gate_drive_o[0]))
		else $error("Low gate too soon after high.");
	gap_lh_a: assert property ($fell(low_gate_drive_o[0]) |-> quiet_s(high_gate_drive_o[0]))
		else $error("High gate too soon after low.");
	pready_a: assert property (pready_o)
		else $error("Bus ready dropped.");
	slverr_a: assert property (pslverr_o |-> psel_i && penable_i)
		else $error("Bus error outside access.");
	off_gate_a: assert property (!channel_enable_i[0] [*8] |-> !high_gate_drive_o[0])
		else $error("Switching while disabled.");
	pg_idle_a: assert property ((!channel_enable_i[0] || !soft_start_done_i[0]) [*8] |-> !powergood_o[0])
		else $error("Powergood before soft-start end.");
	pg_rise_a: assert property ($rose(powergood_o[0]) |-> in_cnt_reg >= PG_RISE_CYCLES)
		else $error("Powergood rose early.");
	pg_fall_a: assert property (out_cnt_reg >= 16'h0028 |-> !powergood_o[0])
		else $error("Powergood fell late.");
	oc_cut_a: assert property (overcurrent_limit_i[0] [*8] |-> !high_gate_drive_o[0])
		else $error("High gate on in overcurrent.");
	dis_gate_a: assert property (discharge_o[0] |-> !high_gate_drive_o[0] && !low_gate_drive_o[0])
		else $error("Discharge while switching.");
	dis_open_a: assert property (channel_enable_i[0] [*8] |-> !discharge_o[0])
		else $error("Discharge on while enabled.");
endmodule // bsp_ctrl_asserts

bind bsp_ctrl bsp_ctrl_asserts #(.PG_RISE_CYCLES(PG_RISE_CYCLES)) u_chk (
	.core_clk_i, .reset_i, .psel_i, .penable_i, .pready_o, .pslverr_o,
	.channel_enable_i, .overcurrent_limit_i, .soft_start_done_i,
	.pg_in_window_i, .pg_out_window_i, .high_gate_drive_o,
	.low_gate_drive_o, .discharge_o, .powergood_o
);

/* File: verification/bsp_power_model.sv */
// Behavioural power stage: inductor current seen by the sense network.
module bsp_power_model #(
	parameter int unsigned OC_LEVEL = 8
) (
	input wire logic core_clk_i,
	input wire logic [1:0] high_gate_i,
	input wire logic [1:0] low_gate_i,
	input wire logic oc_enable_i,
	output logic [1:0] overcurrent_o,
	output logic [1:0] zero_cross_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Current ramps while high is on, settles at a load level, decays on low.
	logic [7:0] cur [2] = '{8'h00, 8'h00};
	always @(posedge core_clk_i) begin
		for (int i = 0; i < 2; i++) begin
			if (high_gate_i[i] && cur[i] < 8'h10) begin
				cur[i] <= cur[i] + 8'h01;
			end else if (low_gate_i[i] && cur[i] != 8'h00) begin
				cur[i] <= cur[i] - 8'h01;
			end
		end
	end
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			overcurrent_o[i] = oc_enable_i && cur[i] >= OC_LEVEL;
			zero_cross_o[i] = cur[i] == 8'h00;
		end
	end
endmodule // bsp_power_model

/* File: verification/testbench.sv */
// Self-checking bench of the buck channel sequencer.
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int P = 40;
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, oc_en = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h00000000;
	logic [31:0] prdata_o, rd;
	logic pready_o, pslverr_o, sense_amp_gain_o, er;
	logic [1:0] channel_enable_i = 2'h0, loop_off_i = 2'h3;
	logic [1:0] target_above_residual_i = 2'h0, soft_start_done_i = 2'h0;
	logic [1:0] pg_in_window_i = 2'h0, pg_out_window_i = 2'h0;
	logic [1:0] under_voltage_i = 2'h0, loop_demand_i = 2'h0;
	logic [1:0] overvoltage_i = 2'h0, switch_node_swing_i = 2'h0;
	logic [1:0] switch_node_diode_i = 2'h0;
	logic [1:0] overcurrent_limit_i, zero_cross_detect_i;
	logic [1:0] high_gate_drive_o, low_gate_drive_o, discharge_o, powergood_o;
	logic [7:0] zc_offset_o;
	logic [31:0] rst_val [4] = '{32'h00000000, 32'h00000064, 32'h000000A2,
		32'h00000000};
	int lo [4] = '{47, 0, 5, 2};
	int hi [4] = '{48, 1, 7, 4};
	int n_mismatch = 0, n_tests = 0, nh, nl, mx, mxa;

	bsp_ctrl #(.PG_RISE_CYCLES(50), .UV_CYCLES(50)) u_bsp_ctrl (.*);
	bsp_power_model u_bsp_power_model (.core_clk_i(core_clk_i),
		.high_gate_i(high_gate_drive_o), .low_gate_i(low_gate_drive_o),
		.oc_enable_i(oc_en), .overcurrent_o(overcurrent_limit_i),
		.zero_cross_o(zero_cross_detect_i));

	always #25 core_clk_i = ~core_clk_i;

	task automatic finish_test();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic step(input int c);
		repeat (c) @(posedge core_clk_i);
	endtask

	// One bus transfer; read data and error are taken at the ready edge.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (pready_o !== 1'b1) begin
			n_mismatch++;
			finish_test();
		end
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge core_clk_i);
	endtask

	// Counts gate rises and the longest high run of channel 1.
	task automatic watch(input int c);
		int run;
		logic ph, pl;
		run = 0;
		ph = high_gate_drive_o[0];
		pl = low_gate_drive_o[0];
		nh = 0;
		nl = 0;
		mx = 0;
		repeat (c) begin
			@(posedge core_clk_i);
			if (high_gate_drive_o[0] === 1'b1 && ph !== 1'b1) nh++;
			if (low_gate_drive_o[0] === 1'b1 && pl !== 1'b1) nl++;
			run = (high_gate_drive_o[0] === 1'b1) ? run + 1 : 0;
			if (run > mx) mx = run;
			ph = high_gate_drive_o[0];
			pl = low_gate_drive_o[0];
		end
	endtask

	initial begin
		step(8);
		reset_i <= 1'b0;
		step(1);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 12'(4 * i + 4 * (i / 3)), 32'h00000000);
			`CHK(rd, rst_val[i])
			`CHK(er, 1'(i == 3))
		end
		for (int t = 0; t < 4; t++) begin
			apb(1'b1, 12'h000, 32'(t) << 4);
			step(4);
			`CHK(sense_amp_gain_o, 1'(t < 2))
			`CHK(discharge_o[0], 1'(t == 0 || t == 3))
		end
		apb(1'b1, 12'h004, 32'h00000028);
		channel_enable_i <= 2'h3;
		watch(2 * P);
		`CHK(discharge_o, 2'h0)
		`CHK(nh, 0)
		target_above_residual_i <= 2'h3;
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, 12'h000, 32'h00000030 + 32'(m));
			watch(48 * P);
			`CHK(nh >= lo[m] && nh <= hi[m], 1'b1)
		end
		switch_node_swing_i <= 2'h1;
		overvoltage_i <= 2'h1;
		apb(1'b1, 12'h000, 32'h00000032);
		watch(24 * P);
		mxa = mx;
		`CHK(zc_offset_o[3:0] > bsp_pkg::ZC_OFS_RST, 1'b1)
		`CHK(zc_offset_o[7:4], bsp_pkg::ZC_OFS_RST)
		switch_node_swing_i <= 2'h0;
		switch_node_diode_i <= 2'h1;
		watch(48 * P);
		`CHK(zc_offset_o[3:0] < bsp_pkg::ZC_OFS_RST, 1'b1)
		`CHK(mx < mxa, 1'b1)
		switch_node_diode_i <= 2'h0;
		overvoltage_i <= 2'h0;
		apb(1'b1, 12'h000, 32'h00000030);
		loop_off_i <= 2'h0;
		watch(4 * P);
		`CHK(nl >= 2 && nh >= 2 && mx <= P, 1'b1)
		oc_en <= 1'b1;
		watch(4 * P);
		`CHK(mx < 20 && nh >= 3, 1'b1)
		oc_en <= 1'b0;
		loop_off_i <= 2'h3;
		pg_in_window_i <= 2'h1;
		step(70);
		`CHK(powergood_o[0], 1'b0)
		soft_start_done_i <= 2'h3;
		step(40);
		`CHK(powergood_o[0], 1'b0)
		step(30);
		`CHK(powergood_o, 2'h1)
		apb(1'b0, 12'h00C, 32'h00000000);
		`CHK(rd[17:16], 2'h1)
		pg_in_window_i <= 2'h0;
		pg_out_window_i <= 2'h1;
		step(26);
		`CHK(powergood_o[0], 1'b1)
		step(15);
		`CHK(powergood_o[0], 1'b0)
		pg_out_window_i <= 2'h0;
		under_voltage_i <= 2'h1;
		step(70);
		watch(2 * P);
		`CHK(nh + nl, 0)
		`CHK(high_gate_drive_o[1] | low_gate_drive_o[1], 1'b0)
		apb(1'b0, 12'h00C, 32'h00000000);
		`CHK(rd[18], 1'b1)
		channel_enable_i <= 2'h0;
		under_voltage_i <= 2'h0;
		step(10);
		`CHK(discharge_o, 2'h3)
		apb(1'b0, 12'h00C, 32'h00000000);
		`CHK(rd[19:18], 2'h0)
		finish_test();
	end
endmodule // testbench
